// file: hw/eeprom_command_sequencer.sv
/*
 eeprom command sequencer: axi4-lite register slave, launch checks, array sequencing.
 assumes an eeprom array that answers each request with ack a cycle or more later.
*/
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`default_nettype none
module eeprom_command_sequencer (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output nvm_cmd_pkg::ee_req_s       ee_req,
	input  wire nvm_cmd_pkg::ee_rsp_s  ee_rsp,
	output logic [1:0]                 flash_margin,
	output logic [1:0]                 ee_margin
);
	typedef enum logic [4:0] {
		s_idle  = 5'b00001,
		s_erase = 5'b00010,
		s_prog  = 5'b00100,
		s_read  = 5'b01000,
		s_done  = 5'b10000
	} seq_e;
	seq_e                    state_r;
	logic [2:0]              index_r;
	nvm_cmd_pkg::ccob_word_s ccob_r [6];
	logic [7:0]              status_r;
	logic [7:0]              mode_r;
	logic [7:0]              prot_r;
	logic [7:0]              cmd_r;
	logic [15:0]             addr_r;
	logic [15:0]             cnt_r;
	logic [15:0]             pos_r;
	logic                    wait_r;
	logic                    aw_hold_r;
	logic                    w_hold_r;
	logic [7:0]              awaddr_r;
	logic [31:0]             wdata_r;
	logic [3:0]              wstrb_r;

	////////////////////////////////////////////////////////////////////////////
	// helper functions
	function automatic logic in_ee(input logic [15:0] a, input logic [15:0] n);
		logic [16:0] e;
		e = {1'b0, a} + {1'b0, n};
		in_ee = (a < nvm_cmd_pkg::ee_size) && (e <= {1'b0, nvm_cmd_pkg::ee_size});
	endfunction
	function automatic logic addr_ok(input nvm_cmd_pkg::ccob_word_s w0,
		input logic [15:0] a);
		// bit 23 picks eeprom, else flash
		if (w0.lo[7]) begin
			addr_ok = (w0.lo[6:0] == 7'h00) && (a < nvm_cmd_pkg::ee_size);
		end else begin
			addr_ok = (w0.lo == 8'h00) && (a < nvm_cmd_pkg::flash_size);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// launch checks
	nvm_cmd_pkg::ccob_word_s w0;
	logic [15:0]             l_addr;
	logic [15:0]             l_par;
	logic [7:0]              l_cmd;
	logic                    l_ee;
	logic                    l_ok_idx;
	logic                    l_bad_lvl;
	logic                    l_bad_rng;
	logic                    l_allowed;
	logic                    l_prot;
	logic [15:0]             l_cnt;
	assign w0     = ccob_r[0];
	assign l_cmd  = w0.hi;
	assign l_addr = {ccob_r[1].hi, ccob_r[1].lo};
	assign l_par  = {ccob_r[2].hi, ccob_r[2].lo};
	assign l_ee   = w0.lo[7];
	assign l_cnt  = {13'h0000, index_r} - 16'h0001;
	always_comb begin
		l_ok_idx  = 1'b0;
		l_bad_lvl = 1'b0;
		l_bad_rng = !addr_ok(w0, l_addr);
		l_allowed = 1'b0;
		l_prot    = 1'b0;
		unique case (l_cmd)
			nvm_cmd_pkg::cmd_margin: begin
				l_ok_idx  = (index_r == nvm_cmd_pkg::idx_2);
				l_bad_lvl = !(l_par == nvm_cmd_pkg::margin_normal ||
					l_par == nvm_cmd_pkg::margin_erased ||
					l_par == nvm_cmd_pkg::margin_progd);
				l_allowed = mode_r[0];
			end
			nvm_cmd_pkg::cmd_evsect: begin
				l_ok_idx  = (index_r == nvm_cmd_pkg::idx_2);
				l_bad_rng = !l_ee || !addr_ok(w0, l_addr) || !in_ee(l_addr, l_par);
				l_allowed = mode_r[1];
			end
			nvm_cmd_pkg::cmd_prog: begin
				l_ok_idx  = (index_r >= nvm_cmd_pkg::idx_2) &&
					(index_r <= nvm_cmd_pkg::idx_5);
				l_bad_rng = !l_ee || !addr_ok(w0, l_addr) || !in_ee(l_addr, l_cnt);
				l_allowed = mode_r[2];
				l_prot    = prot_r[l_addr[7:5]];
			end
			nvm_cmd_pkg::cmd_erase: begin
				l_ok_idx  = (index_r == nvm_cmd_pkg::idx_1);
				l_bad_rng = !l_ee || !addr_ok(w0, l_addr);
				l_allowed = mode_r[3];
				l_prot    = prot_r[l_addr[7:5]];
			end
			default: l_ok_idx = 1'b0;
		endcase
	end
	logic l_access_error_flag;
	assign l_access_error_flag = !l_ok_idx || l_bad_lvl || l_bad_rng || !l_allowed;

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite write path
	logic wr_go;
	logic launch;
	logic command_complete_flag_w1c;
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
	assign wr_go         = aw_hold_r && w_hold_r;
	assign command_complete_flag_w1c      = wr_go && awaddr_r == nvm_cmd_pkg::off_status && wstrb_r[0];
	assign launch        = command_complete_flag_w1c && wdata_r[nvm_cmd_pkg::st_command_complete_flag] &&
		status_r[nvm_cmd_pkg::st_command_complete_flag] && state_r == s_idle;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			awaddr_r     <= 8'h00;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_bresp = 2'b00;
	// writes to parameters are ignored while a command runs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			index_r <= 3'h0;
			mode_r  <= nvm_cmd_pkg::mode_rst;
			prot_r  <= nvm_cmd_pkg::prot_rst;
			for (int i = 0; i < 6; i++) begin
				ccob_r[i] <= '0;
			end
		end else if (wr_go && wstrb_r[0] && status_r[nvm_cmd_pkg::st_command_complete_flag]) begin
			unique case (awaddr_r)
				nvm_cmd_pkg::off_index: index_r <= wdata_r[2:0];
				nvm_cmd_pkg::off_objhi: if (index_r <= nvm_cmd_pkg::idx_5) begin
					ccob_r[index_r].hi <= wdata_r[7:0];
				end
				nvm_cmd_pkg::off_objlo: if (index_r <= nvm_cmd_pkg::idx_5) begin
					ccob_r[index_r].lo <= wdata_r[7:0];
				end
				nvm_cmd_pkg::off_mode: mode_r <= wdata_r[7:0];
				nvm_cmd_pkg::off_prot: prot_r <= wdata_r[7:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite read path
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp   = 2'b00;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr)
				nvm_cmd_pkg::off_index:  s_axi_rdata <= {29'h0, index_r};
				nvm_cmd_pkg::off_objhi:  s_axi_rdata <= (index_r <= nvm_cmd_pkg::idx_5) ?
					{24'h0, ccob_r[index_r].hi} : 32'h0;
				nvm_cmd_pkg::off_objlo:  s_axi_rdata <= (index_r <= nvm_cmd_pkg::idx_5) ?
					{24'h0, ccob_r[index_r].lo} : 32'h0;
				nvm_cmd_pkg::off_status: s_axi_rdata <= {24'h0, status_r};
				nvm_cmd_pkg::off_mode:   s_axi_rdata <= {24'h0, mode_r};
				nvm_cmd_pkg::off_prot:   s_axi_rdata <= {24'h0, prot_r};
				nvm_cmd_pkg::off_margin: s_axi_rdata <= {28'h0, ee_margin, flash_margin};
				default:                 s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command sequencer
	logic       seq_mis;
	logic       seq_err;
	logic       seq_unc;
	logic       last;
	logic [7:0] wbyte;
	assign wbyte   = ccob_r[3'(pos_r[1:0]) + nvm_cmd_pkg::idx_2].lo;
	assign seq_mis = state_r == s_read &&
		ee_rsp.rdata != (cmd_r == nvm_cmd_pkg::cmd_prog ? wbyte : nvm_cmd_pkg::ee_erased);
	assign seq_err = wait_r && ee_rsp.ack && (ee_rsp.err || seq_mis);
	assign seq_unc = wait_r && ee_rsp.ack && (ee_rsp.uncorr || seq_mis);
	assign last    = (pos_r + 16'h0001) >= cnt_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= s_idle;
			cmd_r   <= 8'h00;
			addr_r  <= 16'h0000;
			cnt_r   <= 16'h0000;
			pos_r   <= 16'h0000;
			wait_r  <= 1'b0;
		end else begin
			unique case (state_r)
				s_idle: if (launch) begin
					cmd_r  <= l_cmd;
					pos_r  <= 16'h0000;
					wait_r <= 1'b0;
					if (l_access_error_flag || l_prot || l_cmd == nvm_cmd_pkg::cmd_margin) begin
						state_r <= s_done;
					end else if (l_cmd == nvm_cmd_pkg::cmd_evsect) begin
						addr_r  <= l_addr;
						cnt_r   <= l_par;
						state_r <= (l_par == 16'h0000) ? s_done : s_read;
					end else if (l_cmd == nvm_cmd_pkg::cmd_prog) begin
						addr_r  <= l_addr;
						cnt_r   <= l_cnt;
						state_r <= s_prog;
					end else begin
						addr_r  <= l_addr & nvm_cmd_pkg::sector_mask;
						cnt_r   <= nvm_cmd_pkg::sector_bytes;
						state_r <= s_erase;
					end
				end
				s_erase, s_prog: begin
					if (!wait_r) begin
						wait_r <= 1'b1;
					end else if (ee_rsp.ack) begin
						wait_r <= 1'b0;
						pos_r  <= last && state_r == s_prog ? 16'h0000 : pos_r + 16'h0001;
						if (state_r == s_erase) begin
							state_r <= s_read;
							pos_r   <= 16'h0000;
						end else if (last) begin
							state_r <= s_read;
						end
					end
				end
				s_read: begin
					if (!wait_r) begin
						wait_r <= 1'b1;
					end else if (ee_rsp.ack) begin
						wait_r <= 1'b0;
						pos_r  <= pos_r + 16'h0001;
						if (last) begin
							state_r <= s_done;
						end
					end
				end
				s_done: state_r <= s_idle;
				default: state_r <= s_idle;
			endcase
		end
	end
	always_comb begin
		ee_req       = '0;
		ee_req.req   = wait_r && (state_r == s_erase || state_r == s_prog || state_r == s_read);
		ee_req.erase = state_r == s_erase;
		ee_req.write = state_r == s_prog;
		ee_req.addr  = addr_r + pos_r;
		ee_req.wdata = wbyte;
	end

	////////////////////////////////////////////////////////////////////////////
	// status flags and margin levels
	logic clr_err;
	assign clr_err = command_complete_flag_w1c && state_r == s_idle;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r     <= nvm_cmd_pkg::status_rst;
			flash_margin <= 2'b00;
			ee_margin    <= 2'b00;
		end else begin
			if (clr_err) begin
				if (wdata_r[nvm_cmd_pkg::st_access_error_flag]) status_r[nvm_cmd_pkg::st_access_error_flag] <= 1'b0;
				if (wdata_r[nvm_cmd_pkg::st_protection_violation_flag]) status_r[nvm_cmd_pkg::st_protection_violation_flag] <= 1'b0;
			end
			if (launch) begin
				status_r[nvm_cmd_pkg::st_command_complete_flag] <= 1'b0;
				status_r[nvm_cmd_pkg::st_mgs1] <= 1'b0;
				status_r[nvm_cmd_pkg::st_mgs0] <= 1'b0;
				if (l_access_error_flag) begin
					status_r[nvm_cmd_pkg::st_access_error_flag] <= 1'b1;
				end else if (l_prot) begin
					status_r[nvm_cmd_pkg::st_protection_violation_flag] <= 1'b1;
				end else if (l_cmd == nvm_cmd_pkg::cmd_margin) begin
					if (l_ee) ee_margin <= l_par[1:0];
					else flash_margin <= l_par[1:0];
				end
			end
			if (state_r == s_read && seq_err) begin
				status_r[nvm_cmd_pkg::st_mgs1] <= 1'b1;
				if (seq_unc) begin
					status_r[nvm_cmd_pkg::st_mgs0] <= 1'b1;
				end
			end
			if (state_r == s_done) status_r[nvm_cmd_pkg::st_command_complete_flag] <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: hw/nvm_cmd_pkg.sv
/*
 package for the nonvolatile command sequencer: register offsets, fields, codes, limits.
 assumes a 32-bit axi4-lite master and an eeprom array port outside the block.
*/
`default_nettype none
package nvm_cmd_pkg;
	localparam logic [7:0] off_index  = 8'h00;
	localparam logic [7:0] off_objhi  = 8'h04;
	localparam logic [7:0] off_objlo  = 8'h08;
	localparam logic [7:0] off_status = 8'h0c;
	localparam logic [7:0] off_mode   = 8'h10;
	localparam logic [7:0] off_prot   = 8'h14;
	localparam logic [7:0] off_margin = 8'h18;
	localparam int st_command_complete_flag = 7;
	localparam int st_access_error_flag = 5;
	localparam int st_protection_violation_flag = 4;
	localparam int st_mgs1 = 1;
	localparam int st_mgs0 = 0;
	localparam logic [7:0] status_rst = 8'h80;
	localparam logic [7:0] cmd_margin = 8'h0d;
	localparam logic [7:0] cmd_evsect = 8'h10;
	localparam logic [7:0] cmd_prog   = 8'h11;
	localparam logic [7:0] cmd_erase  = 8'h12;
	localparam logic [2:0] idx_0 = 3'h0;
	localparam logic [2:0] idx_1 = 3'h1;
	localparam logic [2:0] idx_2 = 3'h2;
	localparam logic [2:0] idx_5 = 3'h5;
	localparam logic [15:0] margin_normal = 16'h0000;
	localparam logic [15:0] margin_erased = 16'h0001;
	localparam logic [15:0] margin_progd  = 16'h0002;
	localparam logic [15:0] ee_size = 16'h0100;
	localparam logic [15:0] flash_size = 16'hf000;
	localparam logic [15:0] sector_mask = 16'hfffc;
	localparam logic [15:0] sector_bytes = 16'h0004;
	localparam logic [7:0] mode_rst = 8'h0f;
	localparam logic [7:0] prot_rst = 8'h00;
	localparam logic [7:0] ee_erased = 8'hff;
	typedef struct packed {
		logic [7:0]  hi;
		logic [7:0]  lo;
	} ccob_word_s;
	typedef struct packed {
		logic        req;
		logic        write;
		logic        erase;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ee_req_s;
	typedef struct packed {
		logic        ack;
		logic [7:0]  rdata;
		logic        err;
		logic        uncorr;
	} ee_rsp_s;
endpackage
`default_nettype wire

// file: test/eeprom_command_sequencer_props.sv
/* checker for the eeprom command sequencer ports.
 assumes a bind from the bench top onto the design instance. */
`default_nettype none
module eeprom_command_sequencer_props (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_awready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_arready,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire nvm_cmd_pkg::ee_req_s  ee_req,
	input wire nvm_cmd_pkg::ee_rsp_s  ee_rsp,
	input wire logic [1:0]            flash_margin,
	input wire logic [1:0]            ee_margin
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////
	bresp_hold_a: assert property ((s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) and
		(s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid))
		else $error("bvalid not held or not released");
	rresp_hold_a: assert property ((s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) and
		(s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid))
		else $error("rvalid not held or not released");
	resp_okay_a: assert property ((s_axi_bvalid |-> s_axi_bresp == 2'h0) and
		(s_axi_rvalid |-> s_axi_rresp == 2'h0)) else $error("response not okay");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready while bvalid");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	req_hold_a: assert property (ee_req.req && !ee_rsp.ack |=> ee_req.req &&
		$stable(ee_req.addr) && $stable(ee_req.wdata)) else $error("array request unstable");
	ee_bound_a: assert property (ee_req.req |-> ee_req.addr[15:8] == 8'h00)
		else $error("array address past end");
	margin_valid_a: assert property (ee_margin != 2'h3 && flash_margin != 2'h3)
		else $error("margin level invalid");
	margin_idle_a: assert property ($changed({ee_margin, flash_margin}) |-> !ee_req.req)
		else $error("margin changed during array access");
endmodule
`default_nettype wire

// file: test/tb_eeprom_command_sequencer.sv
/* bench for the eeprom command sequencer: axi4-lite tasks, array model, checks.
 assumes the design package and the checker are compiled first. */
`default_nettype none
module tb_eeprom_command_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 aclk;
	logic                 aresetn;
	logic [7:0]           awaddr;
	logic                 awvalid;
	logic                 awready;
	logic [31:0]          wdata;
	logic                 wvalid;
	logic                 wready;
	logic                 bvalid;
	logic [7:0]           araddr;
	logic                 arvalid;
	logic                 arready;
	logic [31:0]          rdata;
	logic                 rvalid;
	nvm_cmd_pkg::ee_req_s ee_req;
	nvm_cmd_pkg::ee_rsp_s ee_rsp;
	logic [1:0]           flash_margin;
	logic [1:0]           ee_margin;
	logic [7:0]           mem [256];
	logic [15:0]          cw [6];
	logic                 inj_err;
	logic                 inj_unc;
	logic [31:0]          rs;
	logic [31:0]          rv;
	int                   cyc;
	int                   errors;
	int                   tests_run;
	////////////////////////////////////////////////////////////////
	eeprom_command_sequencer u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.ee_req(ee_req), .ee_rsp(ee_rsp), .flash_margin(flash_margin),
		.ee_margin(ee_margin));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic conclude();
		if (errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
	endtask
	task automatic ld(input logic [7:0] c, input logic [7:0] b, input logic [15:0] a,
		input logic [15:0] p);
		cw[0] = {c, b};
		cw[1] = a;
		cw[2] = p;
	endtask
	task automatic go(input int n, input logic [2:0] ix, input logic [7:0] e);
		logic [31:0] d;
		for (int i = 0; i < n; i++) begin
			wr(nvm_cmd_pkg::off_index, 32'(i));
			wr(nvm_cmd_pkg::off_objhi, {24'h0, cw[i][15:8]});
			wr(nvm_cmd_pkg::off_objlo, {24'h0, cw[i][7:0]});
		end
		wr(nvm_cmd_pkg::off_index, {29'h0, ix});
		wr(nvm_cmd_pkg::off_status, 32'h30);
		wr(nvm_cmd_pkg::off_status, 32'h80);
		d = 32'h0;
		while (d[7] !== 1'b1) rd(nvm_cmd_pkg::off_status, d);
		chk("status", {24'h0, e}, d);
	endtask
	////////////////////////////////////////////////////////////////
	// array model: acks after a random wait, erase clears a 4-byte sector
	always @(posedge aclk) begin
		rs = lfsr(rs);
		ee_rsp <= '0;
		if (ee_req.req && !ee_rsp.ack && rs[0]) begin
			ee_rsp.ack <= 1'b1;
			ee_rsp.rdata <= mem[ee_req.addr[7:0]];
			ee_rsp.err <= inj_err;
			ee_rsp.uncorr <= inj_unc;
			if (ee_req.write) mem[ee_req.addr[7:0]] <= ee_req.wdata;
			if (ee_req.erase) for (int k = 0; k < 4; k++) mem[{ee_req.addr[7:2], 2'(k)}] <= 8'hff;
		end
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [7:0]  a;
		logic [7:0]  bt [4];
		int          n;
		{aresetn, awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
		{ee_rsp, inj_err, inj_unc, cyc, errors, tests_run} = '0;
		rs = 32'd88323;
		rv = 32'd88323;
		for (int i = 0; i < 256; i++) mem[i] = 8'hff;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(nvm_cmd_pkg::off_status, d);
		chk("status_rst", 32'h80, d);
		rd(nvm_cmd_pkg::off_mode, d);
		chk("mode_rst", 32'h0f, d);
		rd(8'h1c, d);
		chk("unmapped", 32'h0, d);
		for (int b = 0; b < 2; b++) for (int l = 0; l < 4; l++) begin
			ld(nvm_cmd_pkg::cmd_margin, b ? 8'h80 : 8'h00, 16'h0, 16'(l));
			go(3, nvm_cmd_pkg::idx_2, l == 3 ? 8'ha0 : 8'h80);
			chk("margin", l == 3 ? 2 : l, b ? ee_margin : flash_margin);
		end
		ld(nvm_cmd_pkg::cmd_margin, 8'h80, 16'h0, 16'h0001);
		go(3, nvm_cmd_pkg::idx_1, 8'ha0);
		ld(nvm_cmd_pkg::cmd_evsect, 8'h80, 16'h00f0, 16'h0010);
		go(3, nvm_cmd_pkg::idx_2, 8'h80);
		go(3, nvm_cmd_pkg::idx_1, 8'ha0);
		inj_err = 1'b1;
		go(3, nvm_cmd_pkg::idx_2, 8'h82);
		inj_unc = 1'b1;
		go(3, nvm_cmd_pkg::idx_2, 8'h83);
		{inj_err, inj_unc} = 2'h0;
		ld(nvm_cmd_pkg::cmd_evsect, 8'h80, 16'h00fc, 16'h0008);
		go(3, nvm_cmd_pkg::idx_2, 8'ha0);
		ld(nvm_cmd_pkg::cmd_evsect, 8'h81, 16'h0000, 16'h0004);
		go(3, nvm_cmd_pkg::idx_2, 8'ha0);
		for (int it = 0; it < 10; it++) begin
			rv = lfsr(rv);
			a = {1'b0, rv[4:0], 2'h0};
			n = 1 + int'(rv[9:8]);
			ld(nvm_cmd_pkg::cmd_erase, 8'h80, {8'h0, a + 8'(rv[11:10])}, 16'h0);
			go(2, nvm_cmd_pkg::idx_1, 8'h80);
			for (int k = 0; k < 4; k++) chk("erased", 32'hff, {24'h0, mem[a + 8'(k)]});
			ld(nvm_cmd_pkg::cmd_prog, 8'h80, {8'h0, a}, 16'h0);
			for (int k = 0; k < 4; k++) begin
				bt[k] = {rv[8*k +: 7], 1'b0};
				cw[2 + k] = {bt[k], bt[k]};
			end
			inj_err = (it >= 8);
			inj_unc = (it == 9);
			go(2 + n, 3'(1 + n), it == 8 ? 8'h82 : it == 9 ? 8'h83 : 8'h80);
			{inj_err, inj_unc} = 2'h0;
			for (int k = 0; k < 4; k++) chk("prog", k < n ? bt[k] : 8'hff, mem[a + 8'(k)]);
			ld(nvm_cmd_pkg::cmd_evsect, 8'h80, {8'h0, a}, 16'h0004);
			go(3, nvm_cmd_pkg::idx_2, 8'h83);
		end
		ld(nvm_cmd_pkg::cmd_prog, 8'h80, 16'h00fe, 16'h1111);
		go(6, nvm_cmd_pkg::idx_5, 8'ha0);
		chk("no_write", 32'hff, {24'h0, mem[8'hfe]});
		ld(nvm_cmd_pkg::cmd_prog, 8'h80, 16'h0010, 16'h1111);
		go(6, 3'h6, 8'ha0);
		go(2, nvm_cmd_pkg::idx_1, 8'ha0);
		cw[0] = {nvm_cmd_pkg::cmd_prog, 8'h00};
		go(3, nvm_cmd_pkg::idx_2, 8'ha0);
		wr(nvm_cmd_pkg::off_prot, 32'h80);
		cw[0] = {nvm_cmd_pkg::cmd_prog, 8'h80};
		cw[1] = 16'h00fe;
		go(3, nvm_cmd_pkg::idx_2, 8'h90);
		chk("protected", 32'hff, {24'h0, mem[8'hfe]});
		ld(nvm_cmd_pkg::cmd_erase, 8'h80, 16'h00e0, 16'h0);
		go(2, nvm_cmd_pkg::idx_1, 8'h90);
		wr(nvm_cmd_pkg::off_prot, 32'h0);
		go(3, nvm_cmd_pkg::idx_2, 8'ha0);
		wr(nvm_cmd_pkg::off_mode, 32'h0);
		go(2, nvm_cmd_pkg::idx_1, 8'ha0);
		ld(nvm_cmd_pkg::cmd_margin, 8'h80, 16'h0, 16'h1);
		go(3, nvm_cmd_pkg::idx_2, 8'ha0);
		conclude();
	end
endmodule
bind eeprom_command_sequencer eeprom_command_sequencer_props u_props (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.ee_req(ee_req), .ee_rsp(ee_rsp), .flash_margin(flash_margin), .ee_margin(ee_margin));
`default_nettype wire
